// *** rtl/iad_decoder.v ***
// Instruction attribute decoder with decode and completion gating.
// Assumes all inputs synchronous to CLK_I; queues hold entries until taken.
`timescale 1ns/100ps
`include "iad_map.vh"

module iad_decoder (
    input  wire        CLK_I,
    input  wire        RSTN_I,
    input  wire [3:0]  AVS_ADDRESS_I,
    input  wire        AVS_READ_I,
    input  wire        AVS_WRITE_I,
    input  wire [31:0] AVS_WRITEDATA_I,
    input  wire [3:0]  AVS_BYTEENABLE_I,
    output wire [31:0] AVS_READDATA_O,
    output wire        AVS_WAITREQUEST_O,
    input  wire        IQ0_VALID_I,
    input  wire [31:0] IQ0_INSTR_I,
    input  wire        IQ1_VALID_I,
    input  wire [31:0] IQ1_INSTR_I,
    input  wire        CQ_EMPTY_I,
    input  wire        CQ0_VALID_I,
    input  wire        CQ0_FINISHED_I,
    input  wire        CQ0_IN_RS_I,
    input  wire [18:0] CQ0_FLAGS_I,
    input  wire        CQ1_VALID_I,
    input  wire        CQ1_FINISHED_I,
    input  wire [18:0] CQ1_FLAGS_I,
    output wire        DEC0_FIRE_O,
    output wire        DEC0_TAKE_O,
    output wire [2:0]  DEC0_UNIT_O,
    output wire [18:0] DEC0_FLAGS_O,
    output wire [4:0]  UOP_INDEX_O,
    output wire        DEC1_FIRE_O,
    output wire [2:0]  DEC1_UNIT_O,
    output wire [18:0] DEC1_FLAGS_O,
    output wire        PRIV_FAULT_O,
    output wire        RETIRE0_O,
    output wire        RETIRE1_O,
    output wire        REFETCH_O,
    output wire        EXEC_MF_OK_O,
    output wire        EXEC_MT_OK_O
);

    // Attribute table lookup
    function [21:0] classify;
        input [31:0] ins;
        reg   [5:0]  op;
        reg   [9:0]  xo;
        reg   [9:0]  spr;
        reg          lk;
        reg          no_dec;
        reg   [2:0]  u;
        reg   [18:0] f;
        begin
            op     = ins[31:26];
            xo     = ins[10:1];
            spr    = {ins[15:11], ins[20:16]};
            lk     = ins[0];
            no_dec = ins[23];
            u      = `IAD_U_SU;
            f      = 19'h0;
            case (op)
                6'h07: u = `IAD_U_MU;
                6'h12: begin
                    u = `IAD_U_BU;
                    f[`IAD_F_BRANCH] = 1'b1;
                    f[`IAD_F_LINK]   = lk;
                end
                6'h10: begin
                    u = `IAD_U_BU;
                    f[`IAD_F_BRANCH] = 1'b1;
                    f[`IAD_F_LINK]   = lk;
                    f[`IAD_F_COUNT]  = ~no_dec;
                end
                6'h11: begin
                    u = `IAD_U_COMP;
                    f = `IAD_M_REFETCH;
                end
                6'h13: begin
                    case (xo)
                        10'h010: begin
                            u = `IAD_U_BU;
                            f[`IAD_F_BRANCH] = 1'b1;
                            f[`IAD_F_LINK]   = lk;
                            f[`IAD_F_COUNT]  = ~no_dec;
                        end
                        10'h210: begin
                            u = `IAD_U_BU;
                            f[`IAD_F_BRANCH] = 1'b1;
                            f[`IAD_F_LINK]   = lk;
                        end
                        10'h000: begin
                            u = `IAD_U_BU;
                            f[`IAD_F_BRANCH] = 1'b1;
                        end
                        10'h096, 10'h032, 10'h033, 10'h026: begin
                            u = `IAD_U_COMP;
                            f = `IAD_M_REFETCH;
                        end
                        default: u = `IAD_U_SU;
                    endcase
                end
                6'h20, 6'h22, 6'h24, 6'h26, 6'h28, 6'h2a, 6'h2c:
                    u = `IAD_U_LSU;
                6'h21, 6'h23, 6'h25, 6'h27, 6'h29, 6'h2b, 6'h2d: begin
                    u = `IAD_U_LSU;
                    f = `IAD_M_UPDATE;
                end
                6'h2e: begin
                    u = `IAD_U_LSU;
                    f = `IAD_M_LMULT;
                end
                6'h2f: begin
                    u = `IAD_U_LSU;
                    f = `IAD_M_SMULT;
                end
                6'h1f: begin
                    case (xo)
                        10'h037, 10'h077, 10'h0b7, 10'h0f7, 10'h137, 10'h177, 10'h1b7: begin
                            u = `IAD_U_LSU;
                            f = `IAD_M_UPDATE;
                        end
                        10'h017, 10'h057, 10'h097, 10'h0d7, 10'h117, 10'h157, 10'h197,
                        10'h216, 10'h256, 10'h316, 10'h396: u = `IAD_U_LSU;
                        10'h014: begin
                            u = `IAD_U_LSU;
                            f[`IAD_F_PRE] = 1'b1;
                        end
                        10'h096: begin
                            u = `IAD_U_LSU;
                            f = `IAD_M_STCX;
                        end
                        10'h312, 10'h236: begin
                            u = `IAD_U_LSU;
                            f[`IAD_F_PRIV] = 1'b1;
                        end
                        10'h3b2, 10'h392, 10'h3d2: begin
                            u = `IAD_U_SU1;
                            f = `IAD_M_TLB;
                        end
                        10'h200: begin
                            u = `IAD_U_BU;
                            f[`IAD_F_PRE] = 1'b1;
                            f[`IAD_F_POST] = 1'b1;
                            f[`IAD_F_BRANCH] = 1'b1;
                        end
                        10'h013: begin
                            u = `IAD_U_SU1;
                            f[`IAD_F_MOVE_FROM_TYPE] = 1'b1;
                            f[`IAD_F_MTSER] = 1'b1;
                        end
                        10'h090: begin
                            f[`IAD_F_SPLIT] = 1'b1;
                            f[`IAD_F_PRE] = 1'b1;
                            f[`IAD_F_POST] = 1'b1;
                            f[`IAD_F_MTSER] = 1'b1;
                            f[`IAD_F_MOVE_TO_TYPE] = 1'b1;
                        end
                        10'h083, 10'h0a3: begin
                            u = `IAD_U_SU1;
                            f[`IAD_F_POST] = 1'b1;
                            f[`IAD_F_MTSER] = 1'b1;
                            f[`IAD_F_PRIV] = 1'b1;
                        end
                        10'h173: begin
                            u = `IAD_U_SU1;
                            f[`IAD_F_MOVE_FROM_TYPE] = 1'b1;
                        end
                        10'h143: begin
                            u = `IAD_U_SU1;
                            f[`IAD_F_MOVE_FROM_TYPE] = 1'b1;
                        end
                        10'h1c3: begin
                            u = `IAD_U_SU1;
                            f[`IAD_F_MOVE_TO_TYPE] = 1'b1;
                            f[`IAD_F_MTSER] = 1'b1;
                        end
                        10'h01a: u = `IAD_U_SU1;
                        10'h00b, 10'h04b, 10'h0eb, 10'h1eb: u = `IAD_U_MU;
                        10'h092: f = `IAD_M_MTMSR;
                        10'h053: begin
                            u = `IAD_U_SU1;
                            f[`IAD_F_MOVE_FROM_TYPE] = 1'b1;
                        end
                        10'h153: begin
                            if (spr == `IAD_SPR_LINK || spr == `IAD_SPR_COUNT) begin
                                u = `IAD_U_SU;
                                f = `IAD_M_MFLC;
                                f[`IAD_F_LINK]  = (spr == `IAD_SPR_LINK);
                                f[`IAD_F_COUNT] = (spr == `IAD_SPR_COUNT);
                            end else begin
                                u = `IAD_U_SU1;
                                f[`IAD_F_MOVE_FROM_TYPE] = 1'b1;
                            end
                        end
                        10'h1d3: begin
                            u = `IAD_U_SU1;
                            if (spr == `IAD_SPR_LINK || spr == `IAD_SPR_COUNT) begin
                                f = `IAD_M_MTLC;
                                f[`IAD_F_LINK]  = (spr == `IAD_SPR_LINK);
                                f[`IAD_F_COUNT] = (spr == `IAD_SPR_COUNT);
                            end else begin
                                f = `IAD_M_MTSPR;
                            end
                        end
                        default: u = `IAD_U_SU;
                    endcase
                end
                default: u = `IAD_U_SU;
            endcase
            classify = {u, f};
        end
    endfunction

    wire [63:0] iq_bus = {IQ1_INSTR_I, IQ0_INSTR_I};
    wire [21:0] cls [0:1];

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_slot
            assign cls[g] = classify(iq_bus[32*g +: 32]);
        end
    endgenerate

    wire [18:0] f0 = cls[0][18:0];
    wire [18:0] f1 = cls[1][18:0];

    reg  [1:0]  ctrl_q;
    reg  [1:0]  post_cnt_q;
    reg  [1:0]  post_cnt_d;
    reg  [4:0]  uop_q;
    reg  [31:0] dec_cnt_q;
    reg  [31:0] ret_cnt_q;
    reg         refetch_q;
    reg         mf_ok_q;
    reg         mt_ok_q;
    reg         ack_q;
    reg  [31:0] rdata_q;
    reg  [31:0] rdata_d;

    // Completion in order from the two oldest slots
    wire ret0 = CQ0_VALID_I & CQ0_FINISHED_I;
    wire ret1 = ret0 & CQ1_VALID_I & CQ1_FINISHED_I
              & ~CQ1_FLAGS_I[`IAD_F_CBB]
              & ~CQ0_FLAGS_I[`IAD_F_CBA]
              & ~CQ0_FLAGS_I[`IAD_F_REFETCH];

    wire post_ret = (ret0 & CQ0_FLAGS_I[`IAD_F_POST])
                  | (ret1 & CQ1_FLAGS_I[`IAD_F_POST]);
    wire post_block = post_ret | (post_cnt_q != 2'h0);

    // Micro-operation sequencing of split instructions
    wire [5:0] uop_total = f0[`IAD_F_EXPAND] ? (6'h20 - {1'b0, IQ0_INSTR_I[25:21]}) : 6'h2;
    wire       uop_last  = ({1'b0, uop_q} == (uop_total - 6'h1));

    wire dec0 = IQ0_VALID_I & ctrl_q[`IAD_CTRL_ENABLE] & ~post_block
              & (~f0[`IAD_F_PRE] | CQ_EMPTY_I);
    wire take0 = dec0 & (~f0[`IAD_F_SPLIT] | uop_last);
    wire dec1 = take0 & IQ1_VALID_I
              & ~f0[`IAD_F_DBA]
              & ~f1[`IAD_F_DBB]
              & ~f1[`IAD_F_PRE];

    // Instructions taken and retired this cycle
    wire [1:0] n_dec = {1'b0, take0} + {1'b0, dec1};
    wire [1:0] n_ret = {1'b0, ret0} + {1'b0, ret1};

    always @* begin
        if (post_ret) begin
            post_cnt_d = `IAD_POST_CYCLES;
        end else if (post_cnt_q != 2'h0) begin
            post_cnt_d = post_cnt_q - 2'h1;
        end else begin
            post_cnt_d = 2'h0;
        end
    end

    // Register bus decode
    wire req     = AVS_READ_I | AVS_WRITE_I;
    wire wr_ctrl = AVS_WRITE_I & ack_q & AVS_BYTEENABLE_I[0]
                 & (AVS_ADDRESS_I == `IAD_OFS_CTRL);

    always @* begin
        case (AVS_ADDRESS_I)
            `IAD_OFS_CTRL:    rdata_d = {30'h0, ctrl_q};
            `IAD_OFS_STATUS:  rdata_d = {25'h0, uop_q, post_cnt_q};
            `IAD_OFS_DEC_CNT: rdata_d = dec_cnt_q;
            `IAD_OFS_RET_CNT: rdata_d = ret_cnt_q;
            default:          rdata_d = 32'h0;
        endcase
    end

    always @(posedge CLK_I) begin
        if (!RSTN_I) begin
            ctrl_q     <= `IAD_CTRL_RESET;
            post_cnt_q <= 2'h0;
            uop_q      <= 5'h0;
            dec_cnt_q  <= 32'h0;
            ret_cnt_q  <= 32'h0;
            refetch_q  <= 1'b0;
            mf_ok_q    <= 1'b0;
            mt_ok_q    <= 1'b0;
            ack_q      <= 1'b0;
            rdata_q    <= 32'h0;
        end else begin
            ack_q      <= req & ~ack_q;
            if (AVS_READ_I & ~ack_q) begin
                rdata_q <= rdata_d;
            end
            if (wr_ctrl) begin
                ctrl_q <= AVS_WRITEDATA_I[1:0];
            end
            post_cnt_q <= post_cnt_d;
            if (take0) begin
                uop_q <= 5'h0;
            end else if (dec0 & f0[`IAD_F_SPLIT]) begin
                uop_q <= uop_q + 5'h1;
            end
            dec_cnt_q  <= dec_cnt_q + {30'h0, n_dec};
            ret_cnt_q  <= ret_cnt_q + {30'h0, n_ret};
            refetch_q  <= ret0 & CQ0_FLAGS_I[`IAD_F_REFETCH];
            mf_ok_q    <= CQ0_VALID_I & CQ0_FLAGS_I[`IAD_F_MFSER] & CQ0_IN_RS_I;
            mt_ok_q    <= CQ0_VALID_I & CQ0_FLAGS_I[`IAD_F_MTSER];
        end
    end

    assign AVS_WAITREQUEST_O = req & ~ack_q;
    assign AVS_READDATA_O    = rdata_q;
    assign DEC0_FIRE_O       = dec0;
    assign DEC0_TAKE_O       = take0;
    assign DEC0_UNIT_O       = cls[0][21:19];
    assign DEC0_FLAGS_O      = f0;
    assign UOP_INDEX_O       = uop_q;
    assign DEC1_FIRE_O       = dec1;
    assign DEC1_UNIT_O       = cls[1][21:19];
    assign DEC1_FLAGS_O      = f1;
    assign PRIV_FAULT_O      = dec0 & f0[`IAD_F_PRIV] & ~ctrl_q[`IAD_CTRL_SUPER];
    assign RETIRE0_O         = ret0;
    assign RETIRE1_O         = ret1;
    assign REFETCH_O         = refetch_q;
    assign EXEC_MF_OK_O      = mf_ok_q;
    assign EXEC_MT_OK_O      = mt_ok_q;

endmodule // iad_decoder

// *** rtl/iad_map.vh ***
// Constants for the instruction attribute decoder: offsets, fields, codes.
// Assumes byte addresses on a 32-bit Avalon-MM slave port.
//
// Overview of operation
// - Decode-break-before instruction decodes only from the oldest decode slot.
// - Decode-break-after instruction stops younger decode in the same cycle.
// - Every decode-break-before instruction also carries decode-break-after.
// - Split instruction issues at decode as a series of internal operations.
// - Pre-synchronising instruction decodes only once all older ones completed.
// - After post-synchronising completion, decode stays blocked for 2 cycles.
// - Wide-source flag marks 64-bit operand need for the interlock.
// - Completion-break-before instruction completes only from the oldest completion slot.
// - Completion-break-after instruction stops younger completion that cycle.
// - Completion-break-after implies before; store-conditional and store-multiple carry before only.
// - Move-from-serialized executes the cycle after oldest and in reservation station.
// - Move-to-serialized executes the cycle after it becomes oldest.
// - Refetch-serialized instruction makes completion trigger a refetch.
// - Privileged instruction executes only in supervisor mode; PRIV_FAULT_O checks slot 0 only, so a slot 1 decode raises no fault.
// - Link-dependent set for linking branches, move-to and move-from link.
// - Count-dependent set for count moves and count-decrementing conditional branches.
// - Update loads and stores go to load/store unit, split, update, all breaks.
// - Load/store multiple: split, expanded, decode breaks; store adds completion-break-before.
// - Link and count moves-to: second simple unit, move-to serialized, completion breaks, branch.
// - Count and link moves-from: simple unit, move-from type, decode breaks.
// - Translation read/search/write: second simple unit, serialized, pre, post, privileged.
// - At most two retire per cycle, in order from the two oldest slots.
`ifndef IAD_MAP_VH
`define IAD_MAP_VH

`define IAD_OFS_CTRL      4'h0
`define IAD_OFS_STATUS    4'h4
`define IAD_OFS_DEC_CNT   4'h8
`define IAD_OFS_RET_CNT   4'hc
`define IAD_CTRL_SUPER    0
`define IAD_CTRL_ENABLE   1
`define IAD_CTRL_RESET    2'h2

`define IAD_POST_CYCLES   2'h2

`define IAD_U_SU          3'h0
`define IAD_U_SU1         3'h1
`define IAD_U_MU          3'h2
`define IAD_U_BU          3'h3
`define IAD_U_LSU         3'h4
`define IAD_U_COMP        3'h5

`define IAD_F_DBB         0
`define IAD_F_DBA         1
`define IAD_F_SPLIT       2
`define IAD_F_UPDATE      3
`define IAD_F_EXPAND      4
`define IAD_F_PRE         5
`define IAD_F_POST        6
`define IAD_F_SRC64       7
`define IAD_F_CBB         8
`define IAD_F_CBA         9
`define IAD_F_MFSER       10
`define IAD_F_MTSER       11
`define IAD_F_REFETCH     12
`define IAD_F_BRANCH      13
`define IAD_F_PRIV        14
`define IAD_F_LINK        15
`define IAD_F_COUNT       16
`define IAD_F_MOVE_FROM_TYPE      17
`define IAD_F_MOVE_TO_TYPE      18
`define IAD_NFLAGS        19

`define IAD_M_UPDATE      19'h0030f
`define IAD_M_LMULT       19'h00017
`define IAD_M_SMULT       19'h00117
`define IAD_M_MTLC        19'h42b00
`define IAD_M_MFLC        19'h20003
`define IAD_M_TLB         19'h04860
`define IAD_M_REFETCH     19'h01300
`define IAD_M_STCX        19'h00140
`define IAD_M_MTMSR       19'h40860
`define IAD_M_MTSPR       19'h40800

`define IAD_SPR_LINK      10'h008
`define IAD_SPR_COUNT     10'h009

`endif

// *** bench/iad_checker_properties.sv ***
// Concurrent checks on the decode and completion gating of the decoder.
// Assumes the decoder top ports and the shared map header.
`timescale 1ns/100ps
`include "iad_map.vh"
module iad_props (
    input wire logic        CLK_I,
    input wire logic        RSTN_I,
    input wire logic        CQ_EMPTY_I,
    input wire logic        CQ0_VALID_I,
    input wire logic        CQ0_IN_RS_I,
    input wire logic [18:0] CQ0_FLAGS_I,
    input wire logic [18:0] CQ1_FLAGS_I,
    input wire logic        DEC0_FIRE_O,
    input wire logic [18:0] DEC0_FLAGS_O,
    input wire logic        DEC1_FIRE_O,
    input wire logic [18:0] DEC1_FLAGS_O,
    input wire logic        RETIRE0_O,
    input wire logic        RETIRE1_O,
    input wire logic        REFETCH_O,
    input wire logic        EXEC_MF_OK_O,
    input wire logic        EXEC_MT_OK_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    sequence s_post_done;
        RETIRE0_O && CQ0_FLAGS_I[`IAD_F_POST] || RETIRE1_O && CQ1_FLAGS_I[`IAD_F_POST];
    endsequence
    sequence s_quiet;
        !DEC0_FIRE_O [*2];
    endsequence
    a_dbb_slot0: assert property (DEC1_FIRE_O |-> !DEC1_FLAGS_O[`IAD_F_DBB])
        else $error("break-before decoded from second slot");
    a_dba_solo: assert property (DEC0_FIRE_O && DEC0_FLAGS_O[`IAD_F_DBA] |-> !DEC1_FIRE_O)
        else $error("younger decode beside break-after");
    a_dbb_pair: assert property (DEC0_FLAGS_O[`IAD_F_DBB] |-> DEC0_FLAGS_O[`IAD_F_DBA])
        else $error("break-before without break-after");
    a_pre_wait: assert property (DEC0_FIRE_O && DEC0_FLAGS_O[`IAD_F_PRE] |-> CQ_EMPTY_I)
        else $error("pre-sync decoded with older work pending");
    a_post_hold: assert property (s_post_done |=> s_quiet)
        else $error("decode inside post-sync hold");
    a_cbb_oldest: assert property (RETIRE1_O |-> RETIRE0_O && !CQ1_FLAGS_I[`IAD_F_CBB])
        else $error("second slot retired out of order or break-before");
    a_cba_solo: assert property (RETIRE0_O && CQ0_FLAGS_I[`IAD_F_CBA] |-> !RETIRE1_O)
        else $error("younger retire beside break-after");
    a_refetch_go: assert property (RETIRE0_O && CQ0_FLAGS_I[`IAD_F_REFETCH] |=> REFETCH_O)
        else $error("refetch not raised after serialized retire");
    a_mf_exec: assert property (CQ0_VALID_I && CQ0_IN_RS_I && CQ0_FLAGS_I[`IAD_F_MFSER]
        |=> EXEC_MF_OK_O)
        else $error("move-from release missing");
    a_mt_exec: assert property (CQ0_VALID_I && CQ0_FLAGS_I[`IAD_F_MTSER] |=> EXEC_MT_OK_O)
        else $error("move-to release missing");
    a_mt_early: assert property (EXEC_MT_OK_O
        |-> $past(CQ0_VALID_I && CQ0_FLAGS_I[`IAD_F_MTSER]))
        else $error("move-to release without oldest entry");
endmodule // iad_props

bind iad_decoder iad_props chk_u (
    .CLK_I(CLK_I), .RSTN_I(RSTN_I), .CQ_EMPTY_I(CQ_EMPTY_I), .CQ0_VALID_I(CQ0_VALID_I),
    .CQ0_IN_RS_I(CQ0_IN_RS_I), .CQ0_FLAGS_I(CQ0_FLAGS_I), .CQ1_FLAGS_I(CQ1_FLAGS_I),
    .DEC0_FIRE_O(DEC0_FIRE_O), .DEC0_FLAGS_O(DEC0_FLAGS_O), .DEC1_FIRE_O(DEC1_FIRE_O),
    .DEC1_FLAGS_O(DEC1_FLAGS_O), .RETIRE0_O(RETIRE0_O), .RETIRE1_O(RETIRE1_O),
    .REFETCH_O(REFETCH_O), .EXEC_MF_OK_O(EXEC_MF_OK_O), .EXEC_MT_OK_O(EXEC_MT_OK_O));

// *** bench/iad_cq_model.sv ***
// Completion queue model driving the two oldest completion slots.
// Assumes retire pulses sampled at the rising edge pop the head entries.
`timescale 1ns/100ps
module iad_cq_model (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ret0_i,
    input  wire logic        ret1_i,
    output logic             empty_o,
    output logic             v0_o,
    output logic             fin0_o,
    output logic             rs0_o,
    output logic [18:0]      fl0_o,
    output logic             v1_o,
    output logic             fin1_o,
    output logic [18:0]      fl1_o
);
    logic [18:0] fq [$];
    int          age [$];
    int          lat [$];
    task automatic push(input logic [18:0] f);
        fq.push_back(f);
        age.push_back(0);
        lat.push_back($urandom_range(3, 0));
    endtask
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            fq.delete();
            age.delete();
            lat.delete();
        end
        for (int k = 0; k < 2; k++) begin
            if ((k == 0 ? ret0_i : ret1_i) && fq.size() > 0) begin
                void'(fq.pop_front());
                void'(age.pop_front());
                void'(lat.pop_front());
            end
        end
        foreach (age[k]) age[k]++;
        // Empty slots show changing junk, not the last entry
        empty_o <= fq.size() == 0;
        v0_o    <= fq.size() > 0;
        fin0_o  <= fq.size() > 0 ? age[0] >= lat[0] : 1'($urandom);
        rs0_o   <= fq.size() > 0 ? age[0] >= 1 : 1'($urandom);
        fl0_o   <= fq.size() > 0 ? fq[0] : 19'($urandom);
        v1_o    <= fq.size() > 1;
        fin1_o  <= fq.size() > 1 ? age[1] >= lat[1] : 1'($urandom);
        fl1_o   <= fq.size() > 1 ? fq[1] : 19'($urandom);
    end
endmodule // iad_cq_model

// *** bench/tb.sv ***
// Self-checking bench for the instruction attribute decoder.
// Assumes the completion queue model and the bound property checker.
`timescale 1ns/100ps
`include "iad_map.vh"
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin err_total++; \
    $display("unexpected %s exp %h got %h", nm, e, s); end end
module tb;
    typedef struct packed {logic [2:0] u; logic [18:0] f; logic [4:0] n; logic p;
        logic [21:0] a1; logic v1;} iad_exp_t;
    logic        CLK_I, RSTN_I, AVS_READ_I, AVS_WRITE_I, IQ0_VALID_I, IQ1_VALID_I;
    logic [3:0]  AVS_ADDRESS_I, AVS_BYTEENABLE_I;
    logic [31:0] AVS_WRITEDATA_I, IQ0_INSTR_I, IQ1_INSTR_I, AVS_READDATA_O;
    logic        CQ_EMPTY_I, CQ0_VALID_I, CQ0_FINISHED_I, CQ0_IN_RS_I, CQ1_VALID_I, CQ1_FINISHED_I;
    logic [18:0] CQ0_FLAGS_I, CQ1_FLAGS_I, DEC0_FLAGS_O, DEC1_FLAGS_O;
    logic [2:0]  DEC0_UNIT_O, DEC1_UNIT_O;
    logic [4:0]  UOP_INDEX_O;
    logic        AVS_WAITREQUEST_O, DEC0_FIRE_O, DEC0_TAKE_O, DEC1_FIRE_O, PRIV_FAULT_O;
    logic        RETIRE0_O, RETIRE1_O, REFETCH_O, EXEC_MF_OK_O, EXEC_MT_OK_O, sup;
    int          err_total, n_checks, cyc, nf;
    iad_exp_t    dq [$];
    logic [31:0] rq [$];
    // add mullw lwzu stwu lmw stmw mtlr mtctr mflr mfctr tlbwe tlbre tlbsx bl bdnz
    logic [31:0] ins_t [15] = '{32'h7c000214, 32'h7c0001d6, 32'h84610008, 32'h94610008,
        32'hb8010000, 32'hbc010000, 32'h7c0803a6, 32'h7c0903a6, 32'h7c0802a6, 32'h7c0902a6,
        32'h7c0007a4, 32'h7c000764, 32'h7c000724, 32'h48000001, 32'h42000000};
    logic [21:0] at_t [15] = '{{3'h0, 19'h0}, {3'h2, 19'h0}, {3'h4, 19'h0030f}, {3'h4, 19'h0030f},
        {3'h4, 19'h00017}, {3'h4, 19'h00117}, {3'h1, 19'h4ab00}, {3'h1, 19'h52b00},
        {3'h0, 19'h28003}, {3'h0, 19'h30003}, {3'h1, 19'h04860}, {3'h1, 19'h04860},
        {3'h1, 19'h04860}, {3'h3, 19'h0a000}, {3'h3, 19'h12000}};

    iad_decoder dut_u (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
        .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
        .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_READDATA_O(AVS_READDATA_O),
        .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .IQ0_VALID_I(IQ0_VALID_I),
        .IQ0_INSTR_I(IQ0_INSTR_I), .IQ1_VALID_I(IQ1_VALID_I), .IQ1_INSTR_I(IQ1_INSTR_I),
        .CQ_EMPTY_I(CQ_EMPTY_I), .CQ0_VALID_I(CQ0_VALID_I), .CQ0_FINISHED_I(CQ0_FINISHED_I),
        .CQ0_IN_RS_I(CQ0_IN_RS_I), .CQ0_FLAGS_I(CQ0_FLAGS_I), .CQ1_VALID_I(CQ1_VALID_I),
        .CQ1_FINISHED_I(CQ1_FINISHED_I), .CQ1_FLAGS_I(CQ1_FLAGS_I), .DEC0_FIRE_O(DEC0_FIRE_O),
        .DEC0_TAKE_O(DEC0_TAKE_O), .DEC0_UNIT_O(DEC0_UNIT_O), .DEC0_FLAGS_O(DEC0_FLAGS_O),
        .UOP_INDEX_O(UOP_INDEX_O), .DEC1_FIRE_O(DEC1_FIRE_O), .DEC1_UNIT_O(DEC1_UNIT_O),
        .DEC1_FLAGS_O(DEC1_FLAGS_O), .PRIV_FAULT_O(PRIV_FAULT_O), .RETIRE0_O(RETIRE0_O),
        .RETIRE1_O(RETIRE1_O), .REFETCH_O(REFETCH_O), .EXEC_MF_OK_O(EXEC_MF_OK_O),
        .EXEC_MT_OK_O(EXEC_MT_OK_O));
    iad_cq_model cq_u (.clk_i(CLK_I), .rst_n_i(RSTN_I), .ret0_i(RETIRE0_O), .ret1_i(RETIRE1_O),
        .empty_o(CQ_EMPTY_I), .v0_o(CQ0_VALID_I), .fin0_o(CQ0_FINISHED_I), .rs0_o(CQ0_IN_RS_I),
        .fl0_o(CQ0_FLAGS_I), .v1_o(CQ1_VALID_I), .fin1_o(CQ1_FINISHED_I), .fl1_o(CQ1_FLAGS_I));

    initial begin
        CLK_I = 1'b0;
        forever #2 CLK_I = ~CLK_I;
    end

    task automatic summarize();
        if (err_total == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Read: d carries the expected word; write: d is the data
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        AVS_ADDRESS_I   <= a;
        AVS_WRITE_I     <= w;
        AVS_READ_I      <= !w;
        AVS_WRITEDATA_I <= d;
        if (!w) rq.push_back(d);
        do @(posedge CLK_I); while (AVS_WAITREQUEST_O !== 1'b0);
        AVS_WRITE_I <= 1'b0;
        AVS_READ_I  <= 1'b0;
        @(posedge CLK_I);
    endtask

    // Hold slot 0 until consumed, then hand its flags to the completion queue
    task automatic issue(input int i, input logic [4:0] rt);
        iad_exp_t e;
        int       j;
        e.u = at_t[i][21:19];
        e.f = at_t[i][18:0];
        e.n = e.f[`IAD_F_EXPAND] ? 5'(32 - rt) : (e.f[`IAD_F_SPLIT] ? 5'd2 : 5'd1);
        e.p = e.f[`IAD_F_PRIV] && !sup;
        j = $urandom_range(2, 0);
        e.a1 = at_t[j];
        e.v1 = 1'($urandom);
        dq.push_back(e);
        IQ0_INSTR_I <= e.f[`IAD_F_EXPAND] ? ins_t[i] | {6'h0, rt, 21'h0} : ins_t[i];
        IQ0_VALID_I <= 1'b1;
        IQ1_INSTR_I <= ins_t[j];
        IQ1_VALID_I <= e.v1;
        do @(posedge CLK_I); while (DEC0_TAKE_O !== 1'b1);
        cq_u.push(e.f);
    endtask

    always @(posedge CLK_I) begin
        iad_exp_t    e;
        logic [31:0] r;
        logic        x1;
        cyc = cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            summarize();
        end
        if (RSTN_I === 1'b1 && DEC0_FIRE_O === 1'b1) nf = nf + 1;
        if (RSTN_I === 1'b1 && DEC0_TAKE_O === 1'b1 && dq.size() > 0) begin
            e = dq.pop_front();
            `CHK("unit", e.u, DEC0_UNIT_O)
            `CHK("flags", e.f, DEC0_FLAGS_O)
            `CHK("uops", e.n, 5'(nf))
            `CHK("privfault", e.p, PRIV_FAULT_O)
            `CHK("uopidx", e.n - 5'd1, UOP_INDEX_O)
            x1 = e.v1 && !e.f[`IAD_F_DBA] && !e.a1[`IAD_F_DBB] && !e.a1[`IAD_F_PRE];
            `CHK("dec1", x1, DEC1_FIRE_O)
            `CHK("unit1", e.a1, {DEC1_UNIT_O, DEC1_FLAGS_O})
            nf = 0;
        end
        if (AVS_READ_I === 1'b1 && AVS_WAITREQUEST_O === 1'b0 && rq.size() > 0) begin
            r = rq.pop_front();
            `CHK("readdata", r, AVS_READDATA_O)
        end
    end

    initial begin
        RSTN_I = 1'b0;
        AVS_ADDRESS_I = 4'h0;
        AVS_READ_I = 1'b0;
        AVS_WRITE_I = 1'b0;
        AVS_WRITEDATA_I = 32'h0;
        AVS_BYTEENABLE_I = 4'hf;
        IQ0_VALID_I = 1'b0;
        IQ0_INSTR_I = 32'h7c000214;
        IQ1_VALID_I = 1'b0;
        IQ1_INSTR_I = 32'h7c000214;
        sup = 1'b0;
        err_total = 0;
        n_checks = 0;
        cyc = 0;
        nf = 0;
        void'($urandom(32'h6b8051d5));
        repeat (5) @(posedge CLK_I);
        RSTN_I <= 1'b1;
        @(posedge CLK_I);
        bus(1'b0, `IAD_OFS_CTRL, 32'h2);
        bus(1'b1, `IAD_OFS_RET_CNT, 32'h55);
        bus(1'b0, `IAD_OFS_RET_CNT, 32'h0);
        bus(1'b1, 4'h3, 32'hff);
        bus(1'b0, 4'h3, 32'h0);
        // User mode first: privileged ops must flag a fault
        for (int i = 0; i < 15; i++) issue(i, 5'(28 + $urandom_range(3, 0)));
        IQ0_VALID_I <= 1'b0;
        cq_u.push(19'h00400);
        cq_u.push(19'h01300);
        bus(1'b1, `IAD_OFS_CTRL, 32'h3);
        sup = 1'b1;
        bus(1'b0, `IAD_OFS_CTRL, 32'h3);
        for (int k = 0; k < 40; k++) issue($urandom_range(14, 0), 5'(28 + $urandom_range(3, 0)));
        IQ0_VALID_I <= 1'b0;
        repeat (40) @(posedge CLK_I);
        summarize();
    end
endmodule // tb
